// *** rtl/mbw_map.svh ***
// Notes on behaviour
// [R1] Function 10h writes successive registers from a start address, 16 at most.
// [R2] Registers of one write are committed one by one in ascending address order.
// [R3] A bad value raises an exception; registers committed before it stay written.
// [R4] Query: address, function, start, count, byte count twice count, data high first.
// [R5] CRC-16 ends every frame, low byte first; reply echoes start and count.
// [R6] A 32-bit item spans two registers: even address upper, odd address lower.
// [R7] The master writes both halves of a 32-bit item in one query; the slave also takes 007Dh written alone, as the testbench does.
// [R8] Operation command registers live only in volatile flops, never in storage.
// [R9] Group setting is -1 for none, or 1 to 31 naming the parent slave; the halves are checked apart, so upper FFFFh with lower 0005h can stand.
// [R10] After reset both group halves read FFFFh, so no group is set.
// [R11] The master accesses both group halves together in one transaction.
// [R12] A slave with a group set accepts queries sent to that group address.
// [R13] The input command pair is readable, writable, and drives the network inputs.
// [R14] Upper input word unused; lower word bits 0 to 15 are the network inputs.
// [R15] The output command pair is read only and shows current output status.
// [R16] Upper output word unused; lower word bits carry sixteen network outputs.
// [R17] Unused upper command words read zero; the input upper word ignores writes, the output upper word refuses them.
// [R18] Bad count or byte count is refused with an exception and no write.
`ifndef MBW_MAP_SVH
`define MBW_MAP_SVH

// ************************************************************
// Function and exception codes
// ************************************************************
`define MBW_FC_READ 8'h03
`define MBW_FC_WRITE_MULTI 8'h10
`define MBW_EXC_FLAG 8'h80
`define MBW_EXC_NONE 8'h00
`define MBW_EXC_ADDR 8'h02
`define MBW_EXC_VALUE 8'h03
`define MBW_BROADCAST 8'h00

// ************************************************************
// Register offsets and values
// ************************************************************
`define MBW_REG_GROUP_UP 16'h0030
`define MBW_REG_GROUP_LO 16'h0031
`define MBW_REG_NIN_UP 16'h007C
`define MBW_REG_NIN_LO 16'h007D
`define MBW_REG_NOUT_UP 16'h007E
`define MBW_REG_NOUT_LO 16'h007F
`define MBW_GROUP_RESET 16'hFFFF
`define MBW_GROUP_MIN 16'h0001
`define MBW_GROUP_MAX 16'h001F
`define MBW_NIN_RESET 16'h0000
`define MBW_MAX_REGS 16'h0010

// ************************************************************
// Frame layout and CRC
// ************************************************************
`define MBW_HDR_LAST_READ 8'h03
`define MBW_HDR_LAST_WRITE 8'h04
`define MBW_LEN_EXC 6'h03
`define MBW_LEN_WRITE 6'h06
`define MBW_LEN_READ_HDR 6'h03
`define MBW_CRC_INIT 16'hFFFF
`define MBW_CRC_POLY 16'hA001

`endif

// *** rtl/mbw_pkg.sv ***
package mbw_pkg;

   typedef enum logic [7:0] {
      ST_ADDR = 8'b0000_0001,
      ST_FUNC = 8'b0000_0010,
      ST_HDR = 8'b0000_0100,
      ST_DATA = 8'b0000_1000,
      ST_CRC = 8'b0001_0000,
      ST_EXEC = 8'b0010_0000,
      ST_RESP = 8'b0100_0000,
      ST_SKIP = 8'b1000_0000
   } mbw_state_t;

   typedef logic [15:0] mbw_word_t;

endpackage

// *** rtl/mbw_crc_step.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "mbw_map.svh"

module mbw_crc_step (
   input wire logic [15:0] crc_in,
   input wire logic [7:0] data_in,
   output logic [15:0] crc_out
);

   // ************************************************************
   // One byte of CRC-16, reflected polynomial
   // ************************************************************
   always_comb
   begin
      crc_out = crc_in ^ {8'h00, data_in};
      for (int i = 0; i < 8; i++)
      begin
         if (crc_out[0])
         begin
            crc_out = (crc_out >> 1) ^ `MBW_CRC_POLY;
         end
         else
         begin
            crc_out = crc_out >> 1;
         end
      end
   end

endmodule
`default_nettype wire

// *** rtl/mbw_multi_write.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "mbw_map.svh"

module mbw_multi_write (
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] station_address,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_gap,
   input wire logic [15:0] network_output_bit,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_valid,
   output logic [15:0] network_input_bit,
   output logic [31:0] group_setting
);

   // ************************************************************
   // State
   // ************************************************************
   mbw_pkg::mbw_state_t state_r, state_nxt;
   logic [7:0] bcnt_r, bcnt_nxt;
   logic [7:0] faddr_r, faddr_nxt;
   logic [7:0] func_r, func_nxt;
   logic [15:0] start_r, start_nxt;
   logic [15:0] count_r, count_nxt;
   logic [7:0] bytes_r, bytes_nxt;
   logic [7:0] hi_r, hi_nxt;
   logic [7:0] err_r, err_nxt;
   logic [3:0] idx_r, idx_nxt;
   logic reply_r, reply_nxt;
   logic [15:0] rx_crc_r, rx_crc_nxt;
   logic [15:0] tx_crc_r, tx_crc_nxt;
   logic [5:0] tidx_r, tidx_nxt;
   logic [7:0] tx_data_r, tx_data_nxt;
   logic tx_valid_r, tx_valid_nxt;
   mbw_pkg::mbw_word_t grp_hi_r, grp_hi_nxt;
   mbw_pkg::mbw_word_t grp_lo_r, grp_lo_nxt;
   mbw_pkg::mbw_word_t nin_r, nin_nxt;
   mbw_pkg::mbw_word_t wbuf_r [16];
   mbw_pkg::mbw_word_t wbuf_nxt [16];

   logic [15:0] rx_crc_base;
   logic [15:0] rx_crc_step;
   logic [15:0] tx_crc_step;
   logic [7:0] tx_body;
   logic [5:0] tlen;
   logic [5:0] trel;
   logic [15:0] rd_addr;
   logic [15:0] ex_addr;
   logic [15:0] cnt_new;
   logic group_on;
   logic is_write;

   // ************************************************************
   // Register map helpers
   // ************************************************************
   function automatic logic is_mapped(input logic [15:0] a);
      is_mapped = (a == `MBW_REG_GROUP_UP) || (a == `MBW_REG_GROUP_LO) ||
                  (a == `MBW_REG_NIN_UP) || (a == `MBW_REG_NIN_LO) ||
                  (a == `MBW_REG_NOUT_UP) || (a == `MBW_REG_NOUT_LO);
   endfunction

   function automatic logic [7:0] wr_check(input logic [15:0] a,
                                           input logic [15:0] v);
      wr_check = `MBW_EXC_NONE;
      if (a == `MBW_REG_GROUP_UP)
      begin
         if (v != `MBW_GROUP_RESET && v != 16'h0000)
         begin
            wr_check = `MBW_EXC_VALUE; // R9
         end
      end
      else if (a == `MBW_REG_GROUP_LO)
      begin
         if (v != `MBW_GROUP_RESET &&
             (v < `MBW_GROUP_MIN || v > `MBW_GROUP_MAX))
         begin
            wr_check = `MBW_EXC_VALUE; // R9
         end
      end
      else if (a != `MBW_REG_NIN_UP && a != `MBW_REG_NIN_LO)
      begin
         wr_check = `MBW_EXC_ADDR; // R15
      end
   endfunction

   // ************************************************************
   // CRC steps
   // ************************************************************
   assign rx_crc_base = (state_r == mbw_pkg::ST_ADDR) ? `MBW_CRC_INIT
                                                       : rx_crc_r;

   mbw_crc_step u_rx_crc (
      .crc_in(rx_crc_base),
      .data_in(rx_data),
      .crc_out(rx_crc_step)
   );

   mbw_crc_step u_tx_crc (
      .crc_in(tx_crc_r),
      .data_in(tx_body),
      .crc_out(tx_crc_step)
   );

   // ************************************************************
   // Response bytes
   // ************************************************************
   assign is_write = (func_r == `MBW_FC_WRITE_MULTI);
   assign trel = tidx_r - `MBW_LEN_READ_HDR;
   assign rd_addr = start_r + {11'h000, trel[5:1]};
   assign ex_addr = start_r + {12'h000, idx_r};
   assign group_on = (grp_hi_r == 16'h0000) && (grp_lo_r >= `MBW_GROUP_MIN)
                     && (grp_lo_r <= `MBW_GROUP_MAX);

   always_comb
   begin
      if (err_r != `MBW_EXC_NONE)
      begin
         tlen = `MBW_LEN_EXC;
      end
      else if (is_write)
      begin
         tlen = `MBW_LEN_WRITE;
      end
      else
      begin
         tlen = `MBW_LEN_READ_HDR + {count_r[4:0], 1'b0};
      end
   end

   always_comb
   begin
      logic [15:0] v;
      v = 16'h0000; // R17
      if (rd_addr == `MBW_REG_GROUP_UP)
      begin
         v = grp_hi_r;
      end
      else if (rd_addr == `MBW_REG_GROUP_LO)
      begin
         v = grp_lo_r;
      end
      else if (rd_addr == `MBW_REG_NIN_LO)
      begin
         v = nin_r; // R13
      end
      else if (rd_addr == `MBW_REG_NOUT_LO)
      begin
         v = network_output_bit; // R15 R16
      end
      case (tidx_r)
         6'h00: tx_body = faddr_r;
         6'h01: tx_body = (err_r != `MBW_EXC_NONE) ? (func_r | `MBW_EXC_FLAG)
                                                   : func_r;
         6'h02:
         begin
            if (err_r != `MBW_EXC_NONE)
            begin
               tx_body = err_r;
            end
            else if (is_write)
            begin
               tx_body = start_r[15:8]; // R5
            end
            else
            begin
               tx_body = {count_r[6:0], 1'b0};
            end
         end
         default:
         begin
            if (is_write)
            begin
               case (tidx_r)
                  6'h03: tx_body = start_r[7:0]; // R5
                  6'h04: tx_body = count_r[15:8];
                  default: tx_body = count_r[7:0];
               endcase
            end
            else
            begin
               tx_body = trel[0] ? v[7:0] : v[15:8]; // R6
            end
         end
      endcase
   end

   // ************************************************************
   // Frame receive, execute and reply
   // ************************************************************
   always_comb
   begin
      state_nxt = state_r;
      bcnt_nxt = bcnt_r;
      faddr_nxt = faddr_r;
      func_nxt = func_r;
      start_nxt = start_r;
      count_nxt = count_r;
      bytes_nxt = bytes_r;
      hi_nxt = hi_r;
      err_nxt = err_r;
      idx_nxt = idx_r;
      reply_nxt = reply_r;
      rx_crc_nxt = rx_crc_r;
      tx_crc_nxt = tx_crc_r;
      tidx_nxt = tidx_r;
      tx_data_nxt = tx_data_r;
      tx_valid_nxt = tx_valid_r;
      grp_hi_nxt = grp_hi_r;
      grp_lo_nxt = grp_lo_r;
      nin_nxt = nin_r;
      wbuf_nxt = wbuf_r;
      cnt_new = {count_r[15:8], rx_data};
      if (rx_valid && state_r != mbw_pkg::ST_EXEC &&
          state_r != mbw_pkg::ST_RESP)
      begin
         rx_crc_nxt = rx_crc_step; // R5
      end
      case (state_r)
         mbw_pkg::ST_ADDR:
         begin
            if (rx_valid)
            begin
               faddr_nxt = rx_data;
               err_nxt = `MBW_EXC_NONE;
               reply_nxt = (rx_data == station_address);
               if (rx_data == station_address || rx_data == `MBW_BROADCAST
                   || (group_on && rx_data == grp_lo_r[7:0])) // R12
               begin
                  state_nxt = mbw_pkg::ST_FUNC;
               end
               else
               begin
                  state_nxt = mbw_pkg::ST_SKIP;
               end
            end
         end
         mbw_pkg::ST_FUNC:
         begin
            if (rx_valid)
            begin
               func_nxt = rx_data;
               bcnt_nxt = 8'h00;
               if (rx_data == `MBW_FC_WRITE_MULTI || rx_data == `MBW_FC_READ)
               begin
                  state_nxt = mbw_pkg::ST_HDR; // R1
               end
               else
               begin
                  state_nxt = mbw_pkg::ST_SKIP;
               end
            end
         end
         mbw_pkg::ST_HDR:
         begin
            if (rx_valid)
            begin
               bcnt_nxt = bcnt_r + 8'h01;
               case (bcnt_r)
                  8'h00: start_nxt[15:8] = rx_data; // R4
                  8'h01: start_nxt[7:0] = rx_data;
                  8'h02: count_nxt[15:8] = rx_data;
                  8'h03: count_nxt[7:0] = rx_data;
                  default: bytes_nxt = rx_data;
               endcase
               if (bcnt_r == `MBW_HDR_LAST_READ && !is_write)
               begin
                  if (cnt_new == 16'h0000 || cnt_new > `MBW_MAX_REGS)
                  begin
                     err_nxt = `MBW_EXC_VALUE;
                  end
                  bcnt_nxt = 8'h00;
                  state_nxt = mbw_pkg::ST_CRC;
               end
               else if (bcnt_r == `MBW_HDR_LAST_WRITE)
               begin
                  if (count_r == 16'h0000 || count_r > `MBW_MAX_REGS ||
                      {8'h00, rx_data} != {count_r[14:0], 1'b0}) // R18
                  begin
                     err_nxt = `MBW_EXC_VALUE; // R18
                  end
                  bcnt_nxt = 8'h00;
                  state_nxt = (rx_data == 8'h00) ? mbw_pkg::ST_CRC
                                                 : mbw_pkg::ST_DATA;
               end
            end
         end
         mbw_pkg::ST_DATA:
         begin
            if (rx_valid)
            begin
               if (!bcnt_r[0])
               begin
                  hi_nxt = rx_data; // R4
               end
               else if (err_r == `MBW_EXC_NONE && bcnt_r[7:5] == 3'b000)
               begin
                  wbuf_nxt[bcnt_r[4:1]] = {hi_r, rx_data};
               end
               if (bcnt_r == bytes_r - 8'h01)
               begin
                  bcnt_nxt = 8'h00;
                  state_nxt = mbw_pkg::ST_CRC;
               end
               else
               begin
                  bcnt_nxt = bcnt_r + 8'h01;
               end
            end
         end
         mbw_pkg::ST_CRC:
         begin
            if (rx_valid)
            begin
               bcnt_nxt = bcnt_r + 8'h01;
               if (bcnt_r[0])
               begin
                  idx_nxt = 4'h0;
                  state_nxt = (rx_crc_step == 16'h0000) ? mbw_pkg::ST_EXEC
                                                        : mbw_pkg::ST_ADDR;
               end
            end
         end
         mbw_pkg::ST_EXEC:
         begin
            if (err_r != `MBW_EXC_NONE)
            begin
               state_nxt = mbw_pkg::ST_RESP; // R18
            end
            else
            begin
               if (is_write)
               begin
                  err_nxt = wr_check(ex_addr, wbuf_r[idx_r]);
                  if (err_nxt == `MBW_EXC_NONE)
                  begin
                     if (ex_addr == `MBW_REG_GROUP_UP)
                     begin
                        grp_hi_nxt = wbuf_r[idx_r]; // R6 R8
                     end
                     else if (ex_addr == `MBW_REG_GROUP_LO)
                     begin
                        grp_lo_nxt = wbuf_r[idx_r]; // R6 R8
                     end
                     else if (ex_addr == `MBW_REG_NIN_LO)
                     begin
                        nin_nxt = wbuf_r[idx_r]; // R13 R14 R8
                     end
                  end
               end
               else if (!is_mapped(ex_addr))
               begin
                  err_nxt = `MBW_EXC_ADDR;
               end
               // Stop at the first bad register, keep earlier commits
               if ({12'h000, idx_r} == count_r - 16'h0001 ||
                   err_nxt != `MBW_EXC_NONE) // R3
               begin
                  state_nxt = mbw_pkg::ST_RESP;
               end
               idx_nxt = idx_r + 4'h1; // R2
            end
            tidx_nxt = 6'h00;
            tx_crc_nxt = `MBW_CRC_INIT;
         end
         mbw_pkg::ST_RESP:
         begin
            if (!reply_r)
            begin
               state_nxt = mbw_pkg::ST_ADDR;
            end
            else if (!tx_valid_r || tx_ready)
            begin
               if (tidx_r < tlen)
               begin
                  tx_data_nxt = tx_body;
                  tx_crc_nxt = tx_crc_step;
                  tx_valid_nxt = 1'b1;
                  tidx_nxt = tidx_r + 6'h01;
               end
               else if (tidx_r == tlen)
               begin
                  tx_data_nxt = tx_crc_r[7:0]; // R5
                  tx_valid_nxt = 1'b1;
                  tidx_nxt = tidx_r + 6'h01;
               end
               else if (tidx_r == tlen + 6'h01)
               begin
                  tx_data_nxt = tx_crc_r[15:8]; // R5
                  tx_valid_nxt = 1'b1;
                  tidx_nxt = tidx_r + 6'h01;
               end
               else
               begin
                  tx_valid_nxt = 1'b0;
                  state_nxt = mbw_pkg::ST_ADDR;
               end
            end
         end
         default:
         begin
            state_nxt = state_r;
         end
      endcase
      if (rx_gap && state_r != mbw_pkg::ST_EXEC &&
          state_r != mbw_pkg::ST_RESP)
      begin
         state_nxt = mbw_pkg::ST_ADDR;
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         state_r <= mbw_pkg::ST_ADDR;
         bcnt_r <= 8'h00;
         faddr_r <= 8'h00;
         func_r <= 8'h00;
         start_r <= 16'h0000;
         count_r <= 16'h0000;
         bytes_r <= 8'h00;
         hi_r <= 8'h00;
         err_r <= `MBW_EXC_NONE;
         idx_r <= 4'h0;
         reply_r <= 1'b0;
         rx_crc_r <= `MBW_CRC_INIT;
         tx_crc_r <= `MBW_CRC_INIT;
         tidx_r <= 6'h00;
         tx_data_r <= 8'h00;
         tx_valid_r <= 1'b0;
         grp_hi_r <= `MBW_GROUP_RESET; // R10
         grp_lo_r <= `MBW_GROUP_RESET; // R10
         nin_r <= `MBW_NIN_RESET;
      end
      else
      begin
         state_r <= state_nxt;
         bcnt_r <= bcnt_nxt;
         faddr_r <= faddr_nxt;
         func_r <= func_nxt;
         start_r <= start_nxt;
         count_r <= count_nxt;
         bytes_r <= bytes_nxt;
         hi_r <= hi_nxt;
         err_r <= err_nxt;
         idx_r <= idx_nxt;
         reply_r <= reply_nxt;
         rx_crc_r <= rx_crc_nxt;
         tx_crc_r <= tx_crc_nxt;
         tidx_r <= tidx_nxt;
         tx_data_r <= tx_data_nxt;
         tx_valid_r <= tx_valid_nxt;
         grp_hi_r <= grp_hi_nxt;
         grp_lo_r <= grp_lo_nxt;
         nin_r <= nin_nxt;
      end
   end

   always_ff @(posedge clock)
   begin
      wbuf_r <= wbuf_nxt;
   end

   assign tx_data = tx_data_r;
   assign tx_valid = tx_valid_r;
   assign network_input_bit = nin_r; // R13 R14
   assign group_setting = {grp_hi_r, grp_lo_r}; // R6 R9

endmodule
`default_nettype wire

// *** verif/mbw_multi_write_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module mbw_multi_write_chk (
   input wire logic clock,
   input wire logic reset,
   input wire logic [7:0] station_address,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_gap,
   input wire logic [15:0] network_output_bit,
   input wire logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic [15:0] network_input_bit,
   input wire logic [31:0] group_setting
);
   // ******************
   // Port assertions
   // ******************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   reset_vals_a: assert property ($fell(reset) |->
      group_setting == 32'hFFFF_FFFF && !tx_valid)
      else $error("Values after reset wrong");
   tx_hold_a: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_data))
      else $error("Reply byte not held");
   tx_drop_a: assert property ($fell(tx_valid) |-> $past(tx_ready))
      else $error("Reply byte dropped unaccepted");
   reply_addr_a: assert property ($rose(tx_valid) |->
      tx_data == station_address)
      else $error("Reply not from own address");
   reply_func_a: assert property ($rose(tx_valid) && tx_ready |=>
      tx_valid && (tx_data & 8'h7F) inside {8'h03, 8'h10})
      else $error("Reply function code wrong");
   group_legal_a: assert property (
      (group_setting[31:16] inside {16'h0000, 16'hFFFF}) &&
      (group_setting[15:0] == 16'hFFFF ||
      group_setting[15:0] inside {[16'h0001:16'h001F]}))
      else $error("Group setting out of range");
   nin_quiet_a: assert property ($changed(network_input_bit) |->
      !tx_valid && !rx_valid)
      else $error("Input word changed outside execution");
   group_quiet_a: assert property ($changed(group_setting) |->
      !tx_valid && !rx_valid)
      else $error("Group changed outside execution");
endmodule

bind mbw_multi_write mbw_multi_write_chk u_chk (.clock(clock),
   .reset(reset), .station_address(station_address), .rx_data(rx_data),
   .rx_valid(rx_valid), .rx_gap(rx_gap), .tx_ready(tx_ready),
   .network_output_bit(network_output_bit), .tx_data(tx_data),
   .tx_valid(tx_valid), .network_input_bit(network_input_bit),
   .group_setting(group_setting));
`default_nettype wire

// *** verif/mbw_master_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module mbw_master_model (
   input wire logic clock,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_gap,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready
);
   // ******************
   // Query sender and reply taker
   // ******************
   initial
   begin
      rx_data = 8'hA5;
      rx_valid = 1'b0;
      rx_gap = 1'b0;
      tx_ready = 1'b0;
   end

   task automatic send(input logic [7:0] q[$]);
      @(posedge clock);
      #1;
      rx_gap = 1'b1;
      foreach (q[i])
      begin
         @(posedge clock);
         #1;
         rx_gap = 1'b0;
         rx_valid = 1'b1;
         rx_data = q[i];
      end
      @(posedge clock);
      #1;
      rx_valid = 1'b0;
      rx_data = ~rx_data;
   endtask

   task automatic recv(output logic [7:0] r[$], input logic slow);
      int idle;
      r = {};
      idle = 0;
      while (idle < 40)
      begin
         @(posedge clock);
         if (tx_valid === 1'b1 && tx_ready === 1'b1)
         begin
            r.push_back(tx_data);
            idle = 0;
         end
         else
            idle++;
         #1;
         tx_ready = slow ? ~tx_ready : 1'b1;
      end
      tx_ready = 1'b0;
   endtask
endmodule
`default_nettype wire

// *** verif/mbw_multi_write_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module mbw_multi_write_tb;
   logic clock;
   logic reset;
   logic [7:0] station_address;
   logic [15:0] nout;
   logic [7:0] rx_data;
   logic rx_valid;
   logic rx_gap;
   logic tx_ready;
   logic [7:0] tx_data;
   logic tx_valid;
   logic [15:0] network_input_bit;
   logic [31:0] group_setting;
   int n_mismatch;
   int n_compared;
   logic [15:0] w17[$];
   logic [7:0] rq[$];

   mbw_multi_write dut (.clock(clock), .reset(reset),
      .station_address(station_address), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_gap(rx_gap), .network_output_bit(nout),
      .tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
      .network_input_bit(network_input_bit), .group_setting(group_setting));
   mbw_master_model m (.clock(clock), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_gap(rx_gap), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready));

   // ******************
   // Access tasks
   // ******************
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i])
      begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++)
            c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      return c;
   endfunction

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic xfer(input logic [7:0] q[$], input logic [7:0] e[$],
                       input logic slow);
      logic [7:0] r[$];
      logic [15:0] c;
      c = crc16(q);
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      if (e.size() > 0)
      begin
         c = crc16(e);
         e.push_back(c[7:0]);
         e.push_back(c[15:8]);
      end
      m.send(q);
      m.recv(r, slow);
      check("reply length", 32'(e.size()), 32'(r.size()));
      foreach (e[i])
         if (i < r.size())
            check("reply byte", 32'(e[i]), 32'(r[i]));
   endtask

   task automatic rd(input logic [15:0] st, input logic [15:0] w[$]);
      logic [7:0] e[$];
      e = {8'h01, 8'h03, 8'(2 * w.size())};
      foreach (w[i])
      begin
         e.push_back(w[i][15:8]);
         e.push_back(w[i][7:0]);
      end
      xfer({8'h01, 8'h03, st[15:8], st[7:0], 8'h00, 8'(w.size())}, e, 1'b0);
   endtask

   task automatic wr(input logic [7:0] sa, input logic [15:0] st,
                     input logic [15:0] w[$], input logic [7:0] ec,
                     input logic slow);
      logic [7:0] q[$];
      logic [7:0] e[$];
      q = {sa, 8'h10, st[15:8], st[7:0], 8'h00, 8'(w.size())};
      e = q;
      q.push_back(8'(2 * w.size()));
      foreach (w[i])
      begin
         q.push_back(w[i][15:8]);
         q.push_back(w[i][7:0]);
      end
      if (ec == 8'hFF)
         e = {};
      else if (ec != 8'h00)
         e = {sa, 8'h90, ec};
      xfer(q, e, slow);
   endtask

   task automatic end_sim;
      if (n_mismatch == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ******************
   // Clock, watchdog and tests
   // ******************
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   initial
   begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      end_sim;
   end

   initial
   begin
      n_mismatch = 0;
      n_compared = 0;
      station_address = 8'h01;
      nout = 16'hC35A;
      reset = 1'b1;
      for (int i = 0; i < 17; i++)
         w17.push_back(16'h0001);
      repeat (8) @(posedge clock);
      #1;
      reset = 1'b0;
      check("group", 32'hFFFF_FFFF, group_setting);
      rd(16'h0030, {16'hFFFF, 16'hFFFF});
      rd(16'h007C, {16'h0000, 16'h0000, 16'h0000, 16'hC35A});
      wr(8'h01, 16'h007C, {16'h1234, 16'hA5C3}, 8'h00, 1'b1);
      check("network_input_bit", 32'h0000_A5C3, 32'(network_input_bit));
      rd(16'h007C, {16'h0000, 16'hA5C3});
      wr(8'h01, 16'h0030, {16'h0000, 16'h0005}, 8'h00, 1'b0);
      check("group", 32'h0000_0005, group_setting);
      wr(8'h05, 16'h007D, {16'h0011}, 8'hFF, 1'b0);
      check("network_input_bit", 32'h0000_0011, 32'(network_input_bit));
      wr(8'h09, 16'h007D, {16'h0022}, 8'hFF, 1'b0);
      check("network_input_bit", 32'h0000_0011, 32'(network_input_bit));
      wr(8'h01, 16'h0030, {16'hFFFF, 16'h0040}, 8'h03, 1'b0);
      check("group", 32'hFFFF_0005, group_setting);
      wr(8'h01, 16'h007D, {16'h0077, 16'h0000}, 8'h02, 1'b0);
      check("network_input_bit", 32'h0000_0077, 32'(network_input_bit));
      wr(8'h01, 16'h007D, w17, 8'h03, 1'b0);
      check("network_input_bit", 32'h0000_0077, 32'(network_input_bit));
      xfer({8'h01, 8'h10, 8'h00, 8'h7D, 8'h00, 8'h01, 8'h04,
         8'h00, 8'h55, 8'h00, 8'h66}, {8'h01, 8'h90, 8'h03}, 1'b0);
      check("network_input_bit", 32'h0000_0077, 32'(network_input_bit));
      m.send({8'h01, 8'h10, 8'h00, 8'h7D, 8'h00, 8'h01, 8'h02, 8'h00,
         8'h44, 8'h12, 8'h34});
      m.recv(rq, 1'b0);
      check("bad crc reply", 32'h0000_0000, 32'(rq.size()));
      check("network_input_bit", 32'h0000_0077, 32'(network_input_bit));
      nout = 16'h3C0F;
      rd(16'h007E, {16'h0000, 16'h3C0F});
      wr(8'h00, 16'h007D, {16'h0033}, 8'hFF, 1'b0);
      check("network_input_bit", 32'h0000_0033, 32'(network_input_bit));
      wr(8'h01, 16'h0030, {16'hFFFF, 16'hFFFF}, 8'h00, 1'b1);
      check("group", 32'hFFFF_FFFF, group_setting);
      end_sim;
   end
endmodule
`default_nettype wire
